// [ram_xfer_pkg.sv]
// Constants and carrier types for the RAM transfer and table executor
package ram_xfer_pkg;
  // Instruction field codes, upper six bits of the ten bit word
  localparam logic [5:0] OP_LOAD_ACC = 6'h2c;
  localparam logic [5:0] OP_SWAP = 6'h2d;
  localparam logic [5:0] OP_SWAP_UP = 6'h2e;
  localparam logic [5:0] OP_SWAP_DOWN = 6'h2f;
  localparam logic [5:0] OP_STORE_ACC = 6'h2b;
  localparam logic [5:0] OP_IMM_ACC = 6'h07;
  // Table reference uses bits 9..6, pointer pair load bits 9..8
  localparam logic [3:0] OP_TABLE_REF = 4'h2;
  localparam logic [1:0] OP_PTR_LOAD = 2'h3;
  localparam logic [9:0] OP_Y_INC = 10'h013;
  localparam logic [9:0] OP_Y_DEC = 10'h017;
  // Widths and sizes
  localparam int WORD_W = 10;
  localparam int PC_W = 13;
  localparam int PCL_W = 7;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int RAM_WORDS = 256;
  localparam int BUS_AW = 4;
  localparam int BUS_DW = 16;
  // Register offsets on the plain register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ACC = 4'h1;
  localparam logic [3:0] REG_PTR = 4'h2;
  localparam logic [3:0] REG_PC = 4'h3;
  localparam logic [3:0] REG_MISC = 4'h4;
  localparam logic [3:0] REG_PAGE = 4'h5;
  // Field positions and reset values
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [2:0] SP_RESET = 3'h7;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [3:0] NIB_MAX = 4'hf;

  // Programmer-visible core registers
  typedef struct packed {
    logic [1:0] w5;
    logic [3:0] b;
    logic [3:0] a;
    logic [3:0] x;
    logic [3:0] y;
  } core_regs_type;

  // Execution phases of one instruction
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_EXEC = 2'b01,
    ST_TREAD = 2'b10,
    ST_TLOAD = 2'b11
  } phase_type;
endpackage

// [ram_transfer_table_exec.sv]
// Executor for RAM transfer, pointer and ROM table instructions
// Overview
// The executor walks a simple two-phase loop. In the fetch phase the PC
// stands on the ROM address port; the ROM answers one clock later, so
// the word is decoded in the execute phase that follows. Every ordinary
// instruction therefore costs two clocks, one instruction cycle.
// The table reference is the only multi-cycle word. It spends two more
// clocks: one to present the table address and one to take the word.
//
// Data pointer
// The RAM nibble is selected by X as the high half and Y as the low
// half. The file selector of larger parts is not modelled, so the data
// RAM is 256 nibbles deep and every X and Y pair is a valid address.
//
// Skip handling
// A skip request is remembered in a single flag. The next word is still
// fetched and takes its full cycle, but nothing it would do is allowed
// to land: no register, no RAM nibble and no stack entry moves. Only the
// PC and the pointer pair tracker advance. A skipped word never raises a new skip, so skips do not
// chain, which keeps the flag a plain one-bit register.
//
// Pointer pair chains
// A pointer pair load directly after another one is dropped. The
// tracker remembers whether the previous executed or skipped word was a
// pointer pair load; this lets a program keep several entry points into
// one block of loads, each setting X and Y once.
//
// Software access
// The register port is for debug and test. The PC may only be written
// while the executor is halted in the fetch phase, so a write never
// tears an instruction in flight. RAM and stack have no reset and no port
// access; the program must set them before use.
//
`timescale 1ns/1ps
`default_nettype none
module ram_transfer_table_exec (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic [ram_xfer_pkg::BUS_AW-1:0] ADDR_I,
  input wire logic [ram_xfer_pkg::BUS_DW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [ram_xfer_pkg::BUS_DW-1:0] RDATA_O,
  output logic [ram_xfer_pkg::PC_W-1:0] ROM_ADDR_O,
  input wire logic [ram_xfer_pkg::WORD_W-1:0] ROM_DATA_I
);
  import ram_xfer_pkg::*;

  // Pointer pair load is decoded for execution and for chain tracking
  function automatic logic is_ptr_load(input logic [WORD_W-1:0] w);
    is_ptr_load = (w[9:8] == OP_PTR_LOAD);
  endfunction

  core_regs_type regs;
  core_regs_type next_regs;
  phase_type phase;
  phase_type next_phase;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic [SP_W-1:0] sp;
  logic [SP_W-1:0] next_sp;
  logic [2:0] page;
  logic run;
  logic skip;
  logic next_skip;
  logic prev_ptr;
  logic next_prev_ptr;
  logic [3:0] ram [0:RAM_WORDS-1];
  logic [PC_W-1:0] stack [0:STACK_DEPTH-1];
  logic ram_we;
  logic [3:0] ram_wdata;
  logic push;
  logic [SP_W-1:0] sp_up;
  logic [SP_W-1:0] sp_down;

  // Decoding of the word that arrives in the execute phase
  wire logic [WORD_W-1:0] word = ROM_DATA_I;
  wire logic [3:0] imm = word[3:0];
  wire logic [5:0] op_hi = word[9:4];
  wire logic [7:0] ram_addr = {regs.x, regs.y};
  wire logic [3:0] ram_q = ram[ram_addr];
  wire logic [3:0] x_xor = regs.x ^ imm;
  wire logic [3:0] y_up = regs.y + 4'h1;
  wire logic [3:0] y_down = regs.y - 4'h1;
  wire logic [PC_W-1:0] pc_inc = pc + 13'h0001;
  wire logic dec_tabref = (word[9:6] == OP_TABLE_REF);
  wire logic dec_ptr = is_ptr_load(word);
  // A pointer load right after another one is suppressed
  wire logic ptr_chain = dec_ptr && prev_ptr;
  wire logic bus_wr_ctrl = WR_I && (ADDR_I == REG_CTRL);
  wire logic bus_wr_pc = WR_I && (ADDR_I == REG_PC);
  wire logic bus_wr_page = WR_I && (ADDR_I == REG_PAGE);

  assign sp_up = sp + 3'h1;
  assign sp_down = sp - 3'h1;
  assign ROM_ADDR_O = pc;

  // Next-state logic of the executor
  // Decoding order matters only where codes could overlap. The RAM
  // transfer group is matched on six bits first; the table reference on
  // four bits and the pointer pair load on two bits come after it, and
  // the fixed Y step words last. Words that match nothing act as no-op
  // and still advance the PC, so an unused code cannot hang the loop.
  // The swap forms write the old accumulator into RAM at the same edge
  // at which the old RAM nibble lands in the accumulator; both read the
  // state before the edge, so no temporary is needed.
  always_comb begin
    next_regs = regs;
    next_phase = phase;
    next_pc = pc;
    next_sp = sp;
    next_skip = skip;
    next_prev_ptr = prev_ptr;
    ram_we = 1'b0;
    ram_wdata = regs.a;
    push = 1'b0;
    case (phase)
      ST_FETCH: begin
        if (run) begin
          next_phase = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_phase = ST_FETCH;
        next_pc = pc_inc;
        next_prev_ptr = dec_ptr;
        next_skip = 1'b0;
        // A skipped word only advances the PC and the pointer pair tracker; no other state moves
        if (skip || ptr_chain) begin
          next_regs = regs;
        end else if (op_hi == OP_LOAD_ACC) begin
          next_regs.a = ram_q;
          next_regs.x = x_xor;
        end else if (op_hi == OP_SWAP) begin
          next_regs.a = ram_q;
          ram_we = 1'b1;
          next_regs.x = x_xor;
        end else if (op_hi == OP_SWAP_DOWN) begin
          next_regs.a = ram_q;
          ram_we = 1'b1;
          next_regs.x = x_xor;
          next_regs.y = y_down;
          next_skip = (y_down == NIB_MAX);
        end else if (op_hi == OP_SWAP_UP) begin
          next_regs.a = ram_q;
          ram_we = 1'b1;
          next_regs.x = x_xor;
          next_regs.y = y_up;
          next_skip = (y_up == NIB_RESET);
        end else if (op_hi == OP_STORE_ACC) begin
          ram_we = 1'b1;
          next_regs.x = x_xor;
        end else if (op_hi == OP_IMM_ACC) begin
          next_regs.a = imm;
        end else if (dec_tabref) begin
          // Push return address, then jump into the table
          next_sp = sp_up;
          push = 1'b1;
          next_pc = {word[5:0], page, regs.a};
          next_phase = ST_TREAD;
        end else if (dec_ptr) begin
          next_regs.x = word[7:4];
          next_regs.y = word[3:0];
        end else if (word == OP_Y_INC) begin
          next_regs.y = y_up;
          next_skip = (y_up == NIB_RESET);
        end else if (word == OP_Y_DEC) begin
          next_regs.y = y_down;
          next_skip = (y_down == NIB_MAX);
        end
      end
      ST_TREAD: begin
        // Table address is on the ROM port; data is back next cycle
        next_phase = ST_TLOAD;
      end
      ST_TLOAD: begin
        next_regs.w5 = word[9:8];
        next_regs.b = word[7:4];
        next_regs.a = word[3:0];
        next_pc = stack[sp];
        next_sp = sp_down;
        next_phase = ST_FETCH;
      end
      default: begin
        next_phase = ST_FETCH;
      end
    endcase
  end

  // Core state; a PC write from software only lands while halted
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      regs <= '0;
      phase <= ST_FETCH;
      pc <= PC_RESET;
      sp <= SP_RESET;
      skip <= 1'b0;
      prev_ptr <= 1'b0;
    end else begin
      regs <= next_regs;
      phase <= next_phase;
      sp <= next_sp;
      skip <= next_skip;
      prev_ptr <= next_prev_ptr;
      if (bus_wr_pc && !run && phase == ST_FETCH) begin
        pc <= WDATA_I[PC_W-1:0];
      end else begin
        pc <= next_pc;
      end
    end
  end

  // Data RAM and return stack have no reset; the program must set them
  // Leaving them without reset lets them map onto plain memory cells.
  // The stack entry is written at the slot above the current pointer,
  // the same slot that the pointer will hold once the push lands, so
  // the pop in the load phase reads back exactly what was stored.
  always_ff @(posedge CLK_I) begin
    if (ram_we) begin
      ram[ram_addr] <= ram_wdata;
    end
    if (push) begin
      stack[sp_up] <= pc_inc;
    end
  end

  // Software control: run enable and table page register
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      run <= 1'b0;
      page <= 3'h0;
    end else begin
      if (bus_wr_ctrl) begin
        run <= WDATA_I[CTRL_RUN_BIT];
      end
      if (bus_wr_page) begin
        page <= WDATA_I[2:0];
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  // Every field sits at the low end of its word and unused bits are
  // zero, so software may mask nothing and compare whole words.
  logic [BUS_DW-1:0] rd_mux;
  always_comb begin
    case (ADDR_I)
      REG_CTRL: rd_mux = {15'h0000, run};
      REG_ACC: rd_mux = {6'h00, regs.w5, regs.b, regs.a};
      REG_PTR: rd_mux = {8'h00, regs.x, regs.y};
      REG_PC: rd_mux = {3'h0, pc};
      REG_MISC: rd_mux = {9'h000, prev_ptr, skip, phase, sp};
      REG_PAGE: rd_mux = {13'h0000, page};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data stands one cycle, zero otherwise
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 16'h0000;
    end else if (RD_I) begin
      RDATA_O <= rd_mux;
    end else begin
      RDATA_O <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [ram_xfer_properties.sv]
// Port-level properties of the RAM transfer and table executor
`timescale 1ns/1ps
`default_nettype none
module ram_xfer_checker (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic [3:0] ADDR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic [12:0] ROM_ADDR_O
);
  import ram_xfer_pkg::*;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // A read of one register, answered in the next cycle
  sequence s_rd(logic [3:0] a);
    RD_I && ADDR_I == a;
  endsequence
  // Stale data would let software read a register twice
  property p_idle; !RD_I |=> RDATA_O == 16'h0000; endproperty
  property p_unm; RD_I && ADDR_I > REG_PAGE |=> RDATA_O == 16'h0000;
  endproperty
  property p_acc; s_rd(REG_ACC) |=> RDATA_O[15:10] == 6'h00; endproperty
  property p_ptr; s_rd(REG_PTR) |=> RDATA_O[15:8] == 8'h00; endproperty
  property p_misc; s_rd(REG_MISC) |=> RDATA_O[15:7] == 9'h000; endproperty
  property p_page; s_rd(REG_PAGE) |=> RDATA_O[15:3] == 13'h0000;
  endproperty
  property p_ctrl; s_rd(REG_CTRL) |=> RDATA_O[15:1] == 15'h0000;
  endproperty
  property p_rst; $rose(RESETN_I) |-> ROM_ADDR_O == 13'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_acc: assert property (p_acc) else $error("acc upper bits");
  a_ptr: assert property (p_ptr) else $error("ptr upper bits");
  a_misc: assert property (p_misc) else $error("misc upper bits");
  a_page: assert property (p_page) else $error("page upper bits");
  a_ctrl: assert property (p_ctrl) else $error("ctrl upper bits");
  a_rst: assert property (p_rst) else $error("program address after reset");
endmodule
bind ram_transfer_table_exec ram_xfer_checker ram_xfer_checker_i (
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .ROM_ADDR_O(ROM_ADDR_O));
`default_nettype wire

// [tb.sv]
// Bench running a short program through the executor
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ram_xfer_pkg::*;
  logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0;
  logic [3:0] addr_i = '0;
  logic [15:0] wdata_i = '0, rdata_o;
  logic [12:0] rom_addr_o;
  logic [9:0] rom_data_i = '0;
  logic [9:0] rom [0:8191];
  localparam logic [9:0] PROG [18] = '{10'h33e, 10'h355, 10'h075, 10'h2b0,
    10'h07a, 10'h2e1, 10'h013, 10'h07c, 10'h017, 10'h07d, 10'h33e, 10'h2c6,
    10'h071, 10'h33e, 10'h2f3, 10'h33e, 10'h2d0, 10'h080};
  int err_count = 0, n_tests = 0, cyc = 0;
  ram_transfer_table_exec ram_transfer_table_exec_i (.CLK_I(clk_i),
    .RESETN_I(resetn_i), .ADDR_I(addr_i), .WDATA_I(wdata_i), .WR_I(wr_i),
    .RD_I(rd_i), .RDATA_O(rdata_o), .ROM_ADDR_O(rom_addr_o),
    .ROM_DATA_I(rom_data_i));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // ROM answers one cycle late; the run needs well under 300 cycles
  always @(posedge clk_i) begin
    rom_data_i <= rom[rom_addr_o];
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      wrap_up;
    end
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check($sformatf("register %0h", a), rdata_o, exp);
  endtask
  // The first read issued here sees the state left by the word before pc; a second sees the state left by the word at pc
  task automatic at_pc(logic [12:0] pc);
    int n = 0;
    while (rom_addr_o !== pc && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    check("program address", {3'h0, rom_addr_o}, {3'h0, pc});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    foreach (rom[i]) rom[i] = 10'h000;
    foreach (PROG[i]) rom[i] = PROG[i];
    rom[33] = 10'h3a5;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(REG_ACC, 16'h0000);
    rd(REG_MISC, 16'h0007);
    rd(4'h6, 16'h0000);
    wr(REG_ACC, 16'hffff);
    rd(REG_ACC, 16'h0000);
    wr(REG_PAGE, 16'h0002);
    rd(REG_PAGE, 16'h0002);
    $display("test registers done");
    wr(REG_CTRL, 16'h0001);
    at_pc(13'd5);
    rd(REG_PTR, 16'h003e);
    at_pc(13'd8);
    rd(REG_PTR, 16'h0020);
    at_pc(13'd10);
    rd(REG_PTR, 16'h002f);
    rd(REG_ACC, 16'h0005);
    at_pc(13'd12);
    rd(REG_ACC, 16'h000a);
    rd(REG_PTR, 16'h005e);
    at_pc(13'd15);
    rd(REG_PTR, 16'h000d);
    rd(REG_ACC, 16'h000a);
    at_pc(13'd17);
    rd(REG_ACC, 16'h0001);
    at_pc(13'h021);
    at_pc(13'd18);
    rd(REG_ACC, 16'h03a5);
    wr(REG_CTRL, 16'h0000);
    rd(REG_MISC, 16'h0007);
    $display("test program done");
    wrap_up;
  end
endmodule
`default_nettype wire
